// File: logic/host_port_pkg.sv
// Constants and types for the host port and byte order block
package host_port_pkg;

  // ****************************************
  // Status byte layout
  // ****************************************
  localparam int          ST_SELFTEST_BIT = 0;
  localparam int          ST_PENDING_BIT  = 3;
  localparam int          ST_LOOPBACK_BIT = 6;
  localparam logic [7:0]  ST_UNUSED_MASK  = 8'hb6;

  // ****************************************
  // Address sequence
  // ****************************************
  localparam logic [7:0]  HDR_HIGH        = 8'hff;
  localparam logic [7:0]  HDR_LOW         = 8'h00;
  localparam logic [2:0]  SEQ_LAST        = 3'h7;
  localparam int          HOST_AW         = 18;
  localparam int          SEG_SHIFT       = 4;

  // ****************************************
  // Test pattern, as fetched with lowest address in bits 7:0
  // ****************************************
  localparam logic [31:0] PAT_OFFSET      = 32'h10;
  localparam logic [31:0] PAT_STEP        = 32'h4;
  localparam logic [1:0]  PAT_LAST        = 2'h2;
  localparam logic [31:0] PAT_BYTES_NAT   = 32'h0f070301;
  localparam logic [31:0] PAT_BYTES_SWP   = 32'h070f0103;
  localparam logic [31:0] PAT_WORD_NAT    = 32'h070f0103;
  localparam logic [31:0] PAT_WORD_SWP    = 32'h0f070301;
  localparam logic [31:0] PAT_LONG_NONE   = 32'h0103070f;
  localparam logic [31:0] PAT_LONG_WSWP   = 32'h070f0103;
  localparam logic [31:0] PAT_LONG_BSWP   = 32'h03010f07;
  localparam logic [31:0] PAT_LONG_BOTH   = 32'h0f070301;

  typedef enum logic [1:0] {OBJ_BYTES, OBJ_WORD, OBJ_LONG} obj_type_t;

  // Swaps the two bytes inside each 16-bit half
  function automatic logic [31:0] swap_half_bytes(input logic [31:0] d);
    return {d[23:16], d[31:24], d[7:0], d[15:8]};
  endfunction

endpackage

// File: logic/order_convert.sv
// Host data order converter for one 32-bit object
`timescale 1ns/100ps
module order_convert
  import host_port_pkg::*;
(
  input  wire logic [31:0] din,
  input  obj_type_t        kind,
  input  wire logic        byte_swap,
  input  wire logic        word_bswap,
  input  wire logic        long_wswap,
  input  wire logic        long_bswap,
  output logic      [31:0] dout
);

  logic [31:0] bytes_fixed;
  logic [31:0] long_tmp;

  always_comb begin
    // Byte-array order first, typed swaps on top of it
    bytes_fixed = byte_swap ? swap_half_bytes(din) : din;
    long_tmp    = long_bswap ? swap_half_bytes(bytes_fixed)
                             : bytes_fixed;
    case (kind)
      OBJ_WORD: begin
        dout = word_bswap ? swap_half_bytes(bytes_fixed)
                          : bytes_fixed;
      end
      OBJ_LONG: begin
        dout = long_wswap ? {long_tmp[15:0], long_tmp[31:16]}
                          : long_tmp;
      end
      default: begin
        dout = bytes_fixed;
      end
    endcase
  end

endmodule // order_convert

// File: logic/host_port_and_byte_order.sv
// Host port channel, bus master and host data order conversion
`timescale 1ns/100ps
module host_port_and_byte_order
  import host_port_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Host side pins
  input  wire logic        bus_init,
  input  wire logic        host_sel_reset,
  input  wire logic        host_sel_status,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_wdata,
  input  wire logic        host_irq_ack,
  output logic      [7:0]  host_rdata,
  output logic             host_irq,
  // Master port toward shared host memory
  output logic             mst_req,
  output logic             mst_we,
  output logic [HOST_AW-1:0] mst_addr,
  output logic      [31:0] mst_wdata,
  input  wire logic [31:0] mst_rdata,
  input  wire logic        mst_ack,
  // Board CPU side
  output logic             cpu_reset,
  output logic             cpu_cmd_irq,
  output logic      [7:0]  cpu_cmd_byte,
  input  wire logic        cpu_cmd_ack,
  input  wire logic        cpu_selftest_pass,
  input  wire logic        cpu_fatal,
  input  wire logic        cpu_loop_fail,
  output logic             cfg_seen,
  output logic      [31:0] cfg_addr,
  input  wire logic        cfg_conv_en,
  input  wire logic        cfg_seg_mode,
  input  wire logic        irq_mem_mode,
  input  wire logic [31:0] irq_addr,
  input  wire logic [31:0] irq_value,
  input  wire logic        cpu_host_irq,
  input  wire logic        cpu_rd_req,
  input  wire logic        cpu_wr_req,
  input  obj_type_t        cpu_obj,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_busy,
  output logic             cpu_rd_done,
  output logic      [31:0] cpu_rd_data,
  output logic             led_error
);

  typedef enum logic [2:0] {M_IDLE, M_PAT, M_CPU_RD, M_CPU_WR, M_IRQ}
    mst_state_t;

  // Longword address to 18-bit bus address
  function automatic logic [HOST_AW-1:0] map_addr(input logic [31:0] a,
                                                  input logic        seg);
    if (seg)
      return {a[29:16], 4'h0} + {2'h0, a[15:0]};
    else
      return a[HOST_AW-1:0];
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [13:0] pin_s1;
  logic [13:0] pin_s2;
  logic        wr_d;
  logic        rd_d;
  logic        ack_d;
  logic        init_s;
  logic        cs_a_s;
  logic        cs_b_s;
  logic        wr_s;
  logic        rd_s;
  logic        iack_s;
  logic [7:0]  wdata_s;
  logic        wr_rise;
  logic        rd_rise;
  logic        iack_rise;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 14'h0;
      pin_s2 <= 14'h0;
    end else begin
      pin_s1 <= {bus_init, host_sel_reset, host_sel_status, host_wr,
                 host_rd, host_irq_ack, host_wdata};
      pin_s2 <= pin_s1;
    end
  end

  assign {init_s, cs_a_s, cs_b_s, wr_s, rd_s, iack_s, wdata_s} = pin_s2;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_d  <= 1'b0;
      rd_d  <= 1'b0;
      ack_d <= 1'b0;
    end else begin
      wr_d  <= wr_s;
      rd_d  <= rd_s;
      ack_d <= iack_s;
    end
  end

  assign wr_rise   = wr_s & ~wr_d;
  assign rd_rise   = rd_s & ~rd_d;
  assign iack_rise = iack_s & ~ack_d;

  // ****************************************
  // Board reset
  // ****************************************
  logic clr;

  // Reads of the reset port decode to nothing at all
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      clr <= 1'b0;
    else
      clr <= (wr_rise & cs_a_s) | init_s;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      cpu_reset <= 1'b0;
    else
      cpu_reset <= clr;
  end

  // ****************************************
  // Status byte and command byte
  // ****************************************
  logic       selftest_ok;
  logic       pending;
  logic       loop_fail;
  logic       cmd_wr;
  logic [7:0] status_byte;

  assign cmd_wr = wr_rise & cs_b_s & ~cs_a_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      selftest_ok <= 1'b0;
    else if (clr)
      selftest_ok <= 1'b0;
    else if (cpu_selftest_pass)
      selftest_ok <= 1'b1;
    else if (cpu_fatal)
      selftest_ok <= 1'b0;
  end

  // New byte wins over a consume in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      pending <= 1'b0;
    else if (clr)
      pending <= 1'b0;
    else if (cmd_wr)
      pending <= 1'b1;
    else if (cpu_cmd_ack)
      pending <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_cmd_byte <= 8'h00;
      cpu_cmd_irq  <= 1'b0;
    end else if (clr) begin
      cpu_cmd_byte <= 8'h00;
      cpu_cmd_irq  <= 1'b0;
    end else begin
      cpu_cmd_irq <= cmd_wr;
      if (cmd_wr)
        cpu_cmd_byte <= wdata_s;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      loop_fail <= 1'b0;
    else
      loop_fail <= cpu_loop_fail;
  end

  always_comb begin
    status_byte                  = 8'h00;
    status_byte[ST_SELFTEST_BIT] = selftest_ok;
    status_byte[ST_PENDING_BIT]  = pending;
    status_byte[ST_LOOPBACK_BIT] = loop_fail;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      host_rdata <= 8'h00;
    else
      host_rdata <= (cs_b_s & ~cs_a_s) ? status_byte : 8'h00;
  end

  // ****************************************
  // Configuration address sequence
  // ****************************************
  logic [2:0] seq_cnt;
  logic       cfg_done;

  // A header mismatch restarts the hunt; an FF may open a new header
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_cnt  <= 3'h0;
      cfg_done <= 1'b0;
      cfg_addr <= 32'h0;
      cfg_seen <= 1'b0;
    end else if (clr) begin
      seq_cnt  <= 3'h0;
      cfg_done <= 1'b0;
      cfg_addr <= 32'h0;
      cfg_seen <= 1'b0;
    end else begin
      cfg_seen <= 1'b0;
      if (cmd_wr && !cfg_done) begin
        if (seq_cnt[2]) begin
          cfg_addr[{seq_cnt[1:0], 3'h0} +: 8] <= wdata_s;
          seq_cnt <= seq_cnt + 3'h1;
          if (seq_cnt == SEQ_LAST) begin
            cfg_done <= 1'b1;
            cfg_seen <= 1'b1;
          end
        end else if (wdata_s == (seq_cnt[1] ? HDR_LOW : HDR_HIGH)) begin
          seq_cnt <= seq_cnt + 3'h1;
        end else begin
          seq_cnt <= (wdata_s == HDR_HIGH) ? 3'h1 : 3'h0;
        end
      end
    end
  end

  // ****************************************
  // Master engine toward shared memory
  // ****************************************
  mst_state_t  state;
  logic        pat_go;
  logic        pat_valid;
  logic [1:0]  pat_idx;
  logic [31:0] pat_word [3];
  obj_type_t   rd_kind;
  logic        irq_pend;
  logic [31:0] pat_base;
  logic [31:0] conv_in;
  logic [31:0] conv_out;
  obj_type_t   conv_kind;

  assign pat_base = cfg_addr + PAT_OFFSET;

  // Host interrupt request waits here until the engine is free
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      irq_pend <= 1'b0;
    else if (clr)
      irq_pend <= 1'b0;
    else if (cpu_host_irq && irq_mem_mode)
      irq_pend <= 1'b1;
    else if (state == M_IDLE && !pat_go)
      irq_pend <= 1'b0;
  end

  // Line interrupt: a new request wins over the host acknowledge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      host_irq <= 1'b0;
    else if (clr)
      host_irq <= 1'b0;
    else if (cpu_host_irq && !irq_mem_mode)
      host_irq <= 1'b1;
    else if (iack_rise)
      host_irq <= 1'b0;
  end

  // All exchange happens through this master; nothing inward is mapped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state       <= M_IDLE;
      pat_go      <= 1'b0;
      pat_valid   <= 1'b0;
      pat_idx     <= 2'h0;
      rd_kind     <= OBJ_BYTES;
      mst_req     <= 1'b0;
      mst_we      <= 1'b0;
      mst_addr    <= '0;
      mst_wdata   <= 32'h0;
      cpu_busy    <= 1'b0;
      cpu_rd_done <= 1'b0;
      cpu_rd_data <= 32'h0;
      for (int i = 0; i < 3; i++)
        pat_word[i] <= 32'h0;
    end else if (clr) begin
      state       <= M_IDLE;
      pat_go      <= 1'b0;
      pat_valid   <= 1'b0;
      mst_req     <= 1'b0;
      mst_we      <= 1'b0;
      cpu_busy    <= 1'b0;
      cpu_rd_done <= 1'b0;
    end else begin
      cpu_rd_done <= 1'b0;
      if (cfg_seen)
        pat_go <= 1'b1;
      case (state)
        M_IDLE: begin
          if (pat_go) begin
            state    <= M_PAT;
            pat_go   <= 1'b0;
            pat_idx  <= 2'h0;
            mst_req  <= 1'b1;
            mst_we   <= 1'b0;
            mst_addr <= pat_base[HOST_AW-1:0];
            cpu_busy <= 1'b1;
          end else if (irq_pend) begin
            state     <= M_IRQ;
            mst_req   <= 1'b1;
            mst_we    <= 1'b1;
            mst_addr  <= map_addr(irq_addr, cfg_seg_mode);
            mst_wdata <= irq_value;
            cpu_busy  <= 1'b1;
          end else if (cpu_rd_req) begin
            state    <= M_CPU_RD;
            rd_kind  <= cpu_obj;
            mst_req  <= 1'b1;
            mst_we   <= 1'b0;
            mst_addr <= map_addr(cpu_addr, cfg_seg_mode);
            cpu_busy <= 1'b1;
          end else if (cpu_wr_req) begin
            state     <= M_CPU_WR;
            mst_req   <= 1'b1;
            mst_we    <= 1'b1;
            mst_addr  <= map_addr(cpu_addr, cfg_seg_mode);
            mst_wdata <= conv_out;
            cpu_busy  <= 1'b1;
          end
        end
        M_PAT: begin
          if (mst_ack) begin
            pat_word[pat_idx] <= mst_rdata;
            if (pat_idx == PAT_LAST) begin
              state     <= M_IDLE;
              mst_req   <= 1'b0;
              pat_valid <= 1'b1;
              cpu_busy  <= 1'b0;
            end else begin
              pat_idx  <= pat_idx + 2'h1;
              mst_addr <= mst_addr + PAT_STEP[HOST_AW-1:0];
            end
          end
        end
        M_CPU_RD: begin
          if (mst_ack) begin
            state       <= M_IDLE;
            mst_req     <= 1'b0;
            cpu_busy    <= 1'b0;
            cpu_rd_done <= 1'b1;
            cpu_rd_data <= conv_out;
          end
        end
        default: begin
          if (mst_ack) begin
            state    <= M_IDLE;
            mst_req  <= 1'b0;
            mst_we   <= 1'b0;
            cpu_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Order derivation from the test pattern
  // ****************************************
  logic        d_bytes;
  logic        d_word;
  logic        d_lw;
  logic        d_lb;
  logic        pat_bad;
  logic [31:0] w_fix;
  logic [31:0] l_fix;

  always_comb begin
    d_bytes = (pat_word[0] == PAT_BYTES_SWP);
    w_fix   = d_bytes ? swap_half_bytes(pat_word[1]) : pat_word[1];
    l_fix   = d_bytes ? swap_half_bytes(pat_word[2]) : pat_word[2];
    d_word  = (w_fix == PAT_WORD_SWP);
    d_lw    = (l_fix == PAT_LONG_WSWP) || (l_fix == PAT_LONG_BOTH);
    d_lb    = (l_fix == PAT_LONG_BSWP) || (l_fix == PAT_LONG_BOTH);
    pat_bad = !(pat_word[0] == PAT_BYTES_NAT || d_bytes)
           || !(w_fix == PAT_WORD_NAT || d_word)
           || !(l_fix == PAT_LONG_NONE || d_lw || d_lb);
  end

  // Error stays up until the board is reset again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      led_error <= 1'b0;
    else if (clr)
      led_error <= 1'b0;
    else if (pat_valid && cfg_conv_en && pat_bad)
      led_error <= 1'b1;
  end

  assign conv_in   = (state == M_CPU_RD) ? mst_rdata : cpu_wdata;
  assign conv_kind = (state == M_CPU_RD) ? rd_kind : OBJ_BYTES;

  // Conversion stays off until a fetched pattern and the enable agree
  order_convert u_conv (
    .din        (conv_in),
    .kind       (conv_kind),
    .byte_swap  (pat_valid & cfg_conv_en & d_bytes),
    .word_bswap (pat_valid & cfg_conv_en & d_word),
    .long_wswap (pat_valid & cfg_conv_en & d_lw),
    .long_bswap (pat_valid & cfg_conv_en & d_lb),
    .dout       (conv_out)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  reset_read_quiet_a: assert property (
    rd_rise && cs_a_s && !wr_rise && !init_s |=> !clr)
    else $error("reset port read disturbed the controller");
  reset_write_clear_a: assert property (
    wr_rise && cs_a_s |=> clr ##1 (!selftest_ok && !pending && !cfg_done))
    else $error("reset port write did not reset the controller");
  selftest_set_a: assert property (
    $rose(selftest_ok) |-> $past(cpu_selftest_pass))
    else $error("self test bit set without a pass");
  cmd_latch_a: assert property (
    cmd_wr && !clr |=> pending && cpu_cmd_irq
                       && cpu_cmd_byte == $past(wdata_s))
    else $error("command byte not latched with interrupt");
  pending_hold_a: assert property (
    pending && !cpu_cmd_ack && !clr |=> pending)
    else $error("pending flag dropped before the byte was read");
  status_read_a: assert property (
    cs_b_s && !cs_a_s |=> host_rdata == $past(status_byte)
                          && (host_rdata & ST_UNUSED_MASK) == 8'h00)
    else $error("status byte read wrong");
  seq_to_fetch_a: assert property (
    cfg_seen && !clr && state == M_IDLE && !irq_pend && !cpu_rd_req
      && !cpu_wr_req ##1 !clr |=> state == M_PAT
      && mst_addr == pat_base[HOST_AW-1:0])
    else $error("address sequence did not start the pattern fetch");
  pattern_error_a: assert property (
    pat_valid && cfg_conv_en && pat_bad && !clr |=> led_error)
    else $error("unmatched test pattern not flagged");
  line_irq_a: assert property (
    cpu_host_irq && !irq_mem_mode && !clr |=> host_irq)
    else $error("bus interrupt line not raised");

  cmd_byte_c: cover property (cmd_wr ##[1:20] cpu_cmd_ack);
  cfg_done_c: cover property (cfg_seen ##[1:40] pat_valid);
  typed_read_c: cover property (cpu_rd_done && rd_kind == OBJ_LONG);
  mem_irq_c: cover property (state == M_IRQ && mst_ack);

endmodule // host_port_and_byte_order

// File: verification/host_mem.sv
// Shared host memory model answering the block's master port
`timescale 1ns/100ps
module host_mem (
  input  wire logic        core_clk,
  input  wire logic        mst_req,
  input  wire logic        mst_we,
  input  wire logic [17:0] mst_addr,
  input  wire logic [31:0] mst_wdata,
  output logic      [31:0] mst_rdata,
  output logic             mst_ack
);
  logic [31:0] mem [int];
  int          wait_n = 0;
  bit          slow   = 1'b0;

  initial begin
    mst_ack   = 1'b0;
    mst_rdata = 32'h0;
  end

  // Host writes the pattern whether conversion is used or not
  task automatic put(input logic [17:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask

  // Alternates prompt and slow answers; data is junk outside the ack cycle
  always @(posedge core_clk) begin
    mst_ack   <= 1'b0;
    mst_rdata <= ~mst_rdata;
    if (mst_req && !mst_ack) begin
      if (wait_n < (slow ? 3 : 0)) begin
        wait_n++;
      end else begin
        wait_n = 0;
        slow   = !slow;
        mst_ack <= 1'b1;
        if (mst_we) begin
          mem[mst_addr] = mst_wdata;
        end
        mst_rdata <= mem.exists(mst_addr) ? mem[mst_addr]
                     : {14'h0, mst_addr} ^ 32'h5a5a0000;
      end
    end
  end
endmodule // host_mem

// File: verification/tb_top.sv
// Self-checking testbench for the host port and byte order block
`timescale 1ns/100ps
module tb_top;
  import host_port_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, bus_init = 1'b0, host_wr = 1'b0;
  logic host_sel_reset = 1'b0, host_sel_status = 1'b0, host_rd = 1'b0;
  logic host_irq_ack = 1'b0, cpu_cmd_ack = 1'b0, cpu_selftest_pass = 1'b0;
  logic cpu_fatal = 1'b0, cpu_loop_fail = 1'b0, cfg_conv_en = 1'b0;
  logic cfg_seg_mode = 1'b0, irq_mem_mode = 1'b0, cpu_host_irq = 1'b0;
  logic cpu_rd_req = 1'b0, cpu_wr_req = 1'b0, mst_ack, mst_req, mst_we;
  logic host_irq, cpu_reset, cpu_cmd_irq, cfg_seen, cpu_busy;
  logic cpu_rd_done, led_error;
  logic [7:0]  host_wdata = 8'h00, host_rdata, cpu_cmd_byte;
  logic [31:0] irq_addr = 32'h0, irq_value = 32'h0, cpu_addr = 32'h0;
  logic [31:0] cpu_wdata = 32'h0, mst_wdata, mst_rdata, cfg_addr;
  logic [31:0] cpu_rd_data, base, a;
  logic [HOST_AW-1:0] mst_addr;
  obj_type_t   cpu_obj = OBJ_BYTES;
  int          err_total = 0, checks = 0, pend = 0, pass = 0, loop = 0;
  int          seen = 0, rst_seen = 0;
  logic [7:0]  cmd_q[$];
  logic [31:0] rd_q[$];

  host_port_and_byte_order uut (.*);
  host_mem mem (.*);

  always #20 core_clk = ~core_clk;

  // Pulses last one cycle, except cpu_reset while bus_init is held, so collect them as they pass
  always @(posedge core_clk) begin
    if (cpu_cmd_irq === 1'b1) cmd_q.push_back(cpu_cmd_byte);
    if (cpu_rd_done === 1'b1) rd_q.push_back(cpu_rd_data);
    if (cfg_seen === 1'b1) seen++;
    if (cpu_reset === 1'b1) rst_seen++;
  end

  // ****
  // Tasks
  // ****
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Strobe held past the two-stage sync, then low long enough to re-arm
  task automatic port_wr(logic rs, logic [7:0] d);
    @(posedge core_clk);
    host_sel_reset  <= rs;
    host_sel_status <= !rs;
    host_wdata      <= d;
    tick(2);
    host_wr <= 1'b1;
    tick(4);
    host_wr <= 1'b0;
    tick(4);
    host_sel_reset  <= 1'b0;
    host_sel_status <= 1'b0;
    tick(3);
  endtask

  task automatic status_chk();
    @(posedge core_clk);
    host_sel_status <= 1'b1;
    host_rd         <= 1'b1;
    tick(6);
    chk("status", {1'b0, loop[0], 2'b00, pend[0], 2'b00, pass[0]},
        host_rdata);
    host_sel_status <= 1'b0;
    host_rd         <= 1'b0;
    tick(2);
  endtask

  task automatic ack_cmd();
    @(posedge core_clk);
    cpu_cmd_ack <= 1'b1;
    @(posedge core_clk);
    cpu_cmd_ack <= 1'b0;
    pend = 0;
    tick(2);
  endtask

  // Eight-byte address sequence; waits until the pattern fetch is over
  task automatic send_cfg(logic [31:0] b);
    for (int i = 0; i < 8; i++) begin
      port_wr(1'b0, i < 2 ? 8'hff : i < 4 ? 8'h00 : b[8*(i-4) +: 8]);
      ack_cmd();
    end
    for (int w = 0; w < 60 && cpu_busy !== 1'b0; w++) tick(1);
    tick(2);
  endtask

  // Expected word is the memory filler at phys, in the announced order
  task automatic cpu_read(obj_type_t kind, logic [31:0] ad,
                          logic [17:0] phys, bit big);
    logic [31:0] d;
    d = {14'h0, phys} ^ 32'h5a5a0000;
    if (big && kind == OBJ_WORD)
      d = {d[23:16], d[31:24], d[7:0], d[15:8]};
    if (big && kind == OBJ_LONG)
      d = {d[7:0], d[15:8], d[23:16], d[31:24]};
    @(posedge core_clk);
    cpu_rd_req <= 1'b1;
    cpu_obj    <= kind;
    cpu_addr   <= ad;
    @(posedge core_clk);
    cpu_rd_req <= 1'b0;
    for (int w = 0; w < 40 && rd_q.size() == 0; w++) tick(1);
    chk("rd_data", d, rd_q.pop_front());
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(79949));
    tick(3);
    rst <= 1'b0;
    tick(3);
    status_chk();
    @(posedge core_clk);
    cpu_selftest_pass <= 1'b1;
    cpu_loop_fail     <= 1'b1;
    @(posedge core_clk);
    cpu_selftest_pass <= 1'b0;
    pass = 1;
    loop = 1;
    status_chk();
    cpu_loop_fail <= 1'b0;
    loop = 0;
    port_wr(1'b0, 8'h5c);
    pend = 1;
    status_chk();
    chk("cmd_byte", 32'h5c, cmd_q.pop_front());
    ack_cmd();
    status_chk();
    base = {14'h0, 18'($urandom) & 18'h3ffc0};
    mem.put(base[17:0] + 18'h10, PAT_BYTES_NAT);
    mem.put(base[17:0] + 18'h14, PAT_WORD_NAT);
    mem.put(base[17:0] + 18'h18, PAT_LONG_NONE);
    send_cfg(base);
    chk("cfg_seen", 1, seen);
    chk("cfg_addr", base, cfg_addr);
    chk("led_error", 0, led_error);
    for (int k = 0; k < 4; k++) begin
      a = {14'h0, 18'($urandom) | 18'h00040} & 32'hfffffffc;
      cpu_read(OBJ_BYTES, a, a[17:0], 1'b0);
    end
    @(posedge core_clk);
    cpu_host_irq <= 1'b1;
    @(posedge core_clk);
    cpu_host_irq <= 1'b0;
    tick(4);
    chk("host_irq", 1, host_irq);
    host_irq_ack <= 1'b1;
    tick(4);
    host_irq_ack <= 1'b0;
    tick(4);
    chk("host_irq", 0, host_irq);
    host_sel_reset <= 1'b1;
    host_rd        <= 1'b1;
    tick(6);
    host_sel_reset <= 1'b0;
    host_rd        <= 1'b0;
    status_chk();
    chk("cpu_reset", 0, rst_seen);
    port_wr(1'b1, 8'($urandom));
    pass = 0;
    tick(4);
    status_chk();
    chk("cpu_reset", 1, rst_seen);
    // A fatal report takes the self-test bit back down
    @(posedge core_clk);
    cpu_selftest_pass <= 1'b1;
    @(posedge core_clk);
    cpu_selftest_pass <= 1'b0;
    cpu_fatal         <= 1'b1;
    @(posedge core_clk);
    cpu_fatal <= 1'b0;
    status_chk();
    // Big-endian host: every pattern field reads back as 01 03 07 0f
    cfg_conv_en <= 1'b1;
    base = {14'h0, 18'($urandom) & 18'h3ffc0};
    for (int j = 0; j < 3; j++)
      mem.put(base[17:0] + 18'h10 + 18'(4 * j), 32'h0f070301);
    send_cfg(base);
    chk("cfg_seen", 2, seen);
    chk("led_error", 0, led_error);
    for (int k = 0; k < 3; k++) begin
      a = {14'h0, 18'($urandom) | 18'h00040} & 32'hfffffffc;
      cpu_read(obj_type_t'(k), a, a[17:0], 1'b1);
    end
    // Segment 070f, offset 0103 lands at 070f0 + 0103
    cfg_seg_mode <= 1'b1;
    cpu_read(OBJ_BYTES, 32'h070f0103, 18'h071f3, 1'b1);
    cfg_seg_mode <= 1'b0;
    @(posedge core_clk);
    irq_mem_mode <= 1'b1;
    irq_addr     <= a ^ 32'h4;
    irq_value    <= $urandom;
    cpu_host_irq <= 1'b1;
    @(posedge core_clk);
    cpu_host_irq <= 1'b0;
    tick(12);
    chk("irq_word", irq_value, mem.mem[irq_addr[17:0]]);
    chk("host_irq", 0, host_irq);
    cpu_addr   <= a;
    cpu_wdata  <= $urandom;
    cpu_wr_req <= 1'b1;
    @(posedge core_clk);
    cpu_wr_req <= 1'b0;
    tick(12);
    chk("wr_word", cpu_wdata, mem.mem[a[17:0]]);
    // Bus init resets as well; then a pattern that fits no host order
    bus_init <= 1'b1;
    tick(4);
    bus_init <= 1'b0;
    tick(6);
    chk("cpu_reset", 5, rst_seen);
    mem.put(base[17:0] + 18'h10, 32'h0f070302);
    send_cfg(base);
    chk("led_error", 1, led_error);
    give_verdict();
  end

  // Whole run needs several hundred cycles
  initial begin
    tick(20000);
    err_total++;
    give_verdict();
  end
endmodule // tb_top
